/* File: design/capture_compare_timer.sv */
`timescale 1ns/1ps
`include "timer_cfg.svh"
module capture_compare_timer #(
    parameter int CHANNELS = `CH_COUNT
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic standby,
    input wire timer_pkg::bus_req_s bus_req,
    output logic [15:0] bus_rdata,
    input wire logic [3:0] ext_count_clock,
    input wire logic [CHANNELS-1:0] capture_in_a,
    input wire logic [CHANNELS-1:0] capture_in_b,
    input wire logic [CHANNELS-1:0] sync_clear_group,
    input wire timer_pkg::pwm_pins_s pwm_raw,
    output timer_pkg::pwm_pins_s pwm_pins,
    output timer_pkg::pwm_pins_s pwm_pins_oe
);
    import timer_pkg::*;

    initial begin
        if (CHANNELS != 5) $error("capture_compare_timer supports five channels");
    end

    logic init;
    assign init = rst | standby;

    logic [7:0] output_level_control;
    logic [7:0] function_control_reg;
    logic [7:0] output_master_enable_reg;
    logic [7:0] timer_mode_reg;
    logic [7:0] counter_control [CHANNELS];
    logic [7:0] io_function_control [CHANNELS];
    logic [15:0] channel_count [CHANNELS];
    logic [15:0] general_compare_capture_a [CHANNELS];
    logic [15:0] general_compare_capture_b [CHANNELS];
    logic [15:0] compare_capture_buffer_a [CHANNELS];
    logic [15:0] compare_capture_buffer_b [CHANNELS];
    logic [2:0] channel_status_reg [CHANNELS];

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
            input logic [1:0] be);
        merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
        edge_hit = sel[1] ? (r | f) : (sel[0] ? f : r);
    endfunction

    logic [3:0] tick;
    prescaler u_pre (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick)
    );

    logic [3:0] clk_lvl;
    logic [3:0] clk_rise;
    logic [3:0] clk_fall;
    sync_edge #(.WIDTH(4)) u_sync_clk (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(ext_count_clock),
        .level(clk_lvl),
        .rise(clk_rise),
        .fall(clk_fall)
    );

    logic [CHANNELS-1:0] cap_a_rise;
    logic [CHANNELS-1:0] cap_a_fall;
    logic [CHANNELS-1:0] cap_b_rise;
    logic [CHANNELS-1:0] cap_b_fall;
    sync_edge #(.WIDTH(CHANNELS)) u_sync_a (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(capture_in_a),
        .level(),
        .rise(cap_a_rise),
        .fall(cap_a_fall)
    );
    sync_edge #(.WIDTH(CHANNELS)) u_sync_b (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(capture_in_b),
        .level(),
        .rise(cap_b_rise),
        .fall(cap_b_fall)
    );

    // Combined mode applies to channels 3 and 4 together
    wire [1:0] comb_sel = function_control_reg[5:4];
    wire comb_active = comb_sel[1];
    wire complementary = comb_sel == 2'(comb_complementary);
    wire phase_count = timer_mode_reg[6];

    // Channel 2 phase counting: clocks A and B are the quadrature pair
    wire phase_up = (clk_rise[0] & ~clk_lvl[1]) | (clk_fall[0] & clk_lvl[1]);
    wire phase_dn = (clk_rise[1] & ~clk_lvl[0]) | (clk_fall[1] & clk_lvl[0]);

    // Complementary mode direction for channels 3 and 4
    logic count_down [2];

    wire [7:0] ch_index = bus_req.addr - `REG_CH_BASE;
    wire ch_space = bus_req.addr >= `REG_CH_BASE;
    wire [3:0] ch_sel = ch_index[7:4];
    wire [3:0] ch_off = ch_index[3:0];

    logic [CHANNELS-1:0] count_tick;
    logic [CHANNELS-1:0] match_a;
    logic [CHANNELS-1:0] match_b;
    logic [CHANNELS-1:0] cap_a;
    logic [CHANNELS-1:0] cap_b;
    logic [CHANNELS-1:0] clear_cnt;
    logic [CHANNELS-1:0] wrap;
    logic [15:0] next_count [CHANNELS];
    logic [CHANNELS-1:0] wr_ch;

    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++) begin : g_ch
            // Keeps buffer and direction indices in range on channels without buffers
            localparam int BUF_IDX = (c >= 3) ? c - 3 : 0;
            wire [2:0] src = counter_control[c][2:0];
            wire [1:0] edge_sel = counter_control[c][4:3];
            wire [1:0] clr = counter_control[c][6:5];
            wire pwm_any = timer_mode_reg[c] | ((c >= 3) && comb_active);
            wire [2:0] io_a = pwm_any ? 3'h0 : io_function_control[c][2:0];
            wire [2:0] io_b = pwm_any ? 3'h0 : io_function_control[c][6:4];
            wire up_down = (c == 2 && phase_count) || (c >= 3 && complementary);
            wire internal_tick = tick[src[1:0]];
            wire ext_tick = edge_hit(edge_sel, clk_rise[src[1:0]], clk_fall[src[1:0]]);
            wire phase_mode = (c == 2) && phase_count;
            wire dec = phase_mode ? phase_dn
                : (c >= 3 && complementary && count_down[BUF_IDX]);
            assign count_tick[c] = phase_mode ? (phase_up | phase_dn)
                : (src[2] ? ext_tick : internal_tick);
            assign match_a[c] = ~io_a[2] & (channel_count[c] == general_compare_capture_a[c]);
            assign match_b[c] = ~io_b[2] & (channel_count[c] == general_compare_capture_b[c]);
            assign cap_a[c] = io_a[2] & edge_hit(io_a[1:0], cap_a_rise[c], cap_a_fall[c]);
            assign cap_b[c] = io_b[2] & edge_hit(io_b[1:0], cap_b_rise[c], cap_b_fall[c]);
            // Match or capture is already selected by the function bits
            assign clear_cnt[c] = (clr == 2'h1 && (match_a[c] | cap_a[c]))
                || (clr == 2'h2 && (match_b[c] | cap_b[c]))
                || (clr == 2'h3 && sync_clear_group[c]);
            assign next_count[c] = dec && up_down ? channel_count[c] - 16'h0001
                : channel_count[c] + 16'h0001;
            assign wrap[c] = count_tick[c] & ~clear_cnt[c] & (dec && up_down
                ? channel_count[c] == 16'h0000 : channel_count[c] == 16'hffff);
            assign wr_ch[c] = bus_req.wr & ch_space & (ch_sel == 4'(c));

            always_ff @(posedge clk_sys) begin
                if (init) begin
                    channel_count[c] <= `CNT_RESET;
                    counter_control[c] <= `CC_RESET;
                    io_function_control[c] <= `IOF_RESET;
                    general_compare_capture_a[c] <= `GR_RESET;
                    general_compare_capture_b[c] <= `GR_RESET;
                    channel_status_reg[c] <= 3'h0;
                end else begin
                    if (wr_ch[c] && ch_off == `CH_CNT) begin
                        channel_count[c] <= merge(channel_count[c], bus_req.wdata,
                            bus_req.byte_en);
                    end else if (clear_cnt[c]) begin
                        channel_count[c] <= 16'h0000;
                    end else if (count_tick[c]) begin
                        channel_count[c] <= next_count[c];
                    end
                    if (wr_ch[c] && ch_off == `CH_CC && bus_req.byte_en[0]) begin
                        counter_control[c] <= bus_req.wdata[7:0] | `CC_FIXED_ONES;
                    end
                    if (wr_ch[c] && ch_off == `CH_IOF && bus_req.byte_en[0]) begin
                        io_function_control[c] <= bus_req.wdata[7:0] | `IOF_RESET;
                    end
                    if (wr_ch[c] && ch_off == `CH_GRA) begin
                        general_compare_capture_a[c] <= merge(general_compare_capture_a[c],
                            bus_req.wdata, bus_req.byte_en);
                    end else if (cap_a[c]) begin
                        general_compare_capture_a[c] <= channel_count[c];
                    end else if (match_a[c] && c >= 3 && function_control_reg[2*BUF_IDX]) begin
                        general_compare_capture_a[c] <= compare_capture_buffer_a[c];
                    end
                    if (wr_ch[c] && ch_off == `CH_GRB) begin
                        general_compare_capture_b[c] <= merge(general_compare_capture_b[c],
                            bus_req.wdata, bus_req.byte_en);
                    end else if (cap_b[c]) begin
                        general_compare_capture_b[c] <= channel_count[c];
                    end else if (match_b[c] && c >= 3 && function_control_reg[2*BUF_IDX+1]) begin
                        general_compare_capture_b[c] <= compare_capture_buffer_b[c];
                    end
                    // A new event wins over a software clear in the same cycle
                    channel_status_reg[c] <= ((wr_ch[c] && ch_off == `CH_FLAGS
                        && bus_req.byte_en[0]) ? channel_status_reg[c] & bus_req.wdata[2:0]
                        : channel_status_reg[c])
                        | {wrap[c], match_b[c] | cap_b[c], match_a[c] | cap_a[c]};
                end
            end

            if (c >= 3) begin : g_buf
                wire en_a = function_control_reg[2*(c-3)];
                wire en_b = function_control_reg[2*(c-3)+1];
                always_ff @(posedge clk_sys) begin
                    if (init) begin
                        compare_capture_buffer_a[c] <= `BR_RESET;
                        compare_capture_buffer_b[c] <= `BR_RESET;
                        count_down[c-3] <= 1'b0;
                    end else begin
                        if (wr_ch[c] && ch_off == `CH_BRA) begin
                            compare_capture_buffer_a[c] <= merge(compare_capture_buffer_a[c],
                                bus_req.wdata, bus_req.byte_en);
                        end else if (en_a && cap_a[c]) begin
                            compare_capture_buffer_a[c] <= general_compare_capture_a[c];
                        end
                        if (wr_ch[c] && ch_off == `CH_BRB) begin
                            compare_capture_buffer_b[c] <= merge(compare_capture_buffer_b[c],
                                bus_req.wdata, bus_req.byte_en);
                        end else if (en_b && cap_b[c]) begin
                            compare_capture_buffer_b[c] <= general_compare_capture_b[c];
                        end
                        // Turn around at the top match and at zero
                        if (!complementary) begin
                            count_down[c-3] <= 1'b0;
                        end else if (count_tick[c] && match_a[c]) begin
                            count_down[c-3] <= 1'b1;
                        end else if (count_tick[c] && channel_count[c] == 16'h0001
                                && count_down[c-3]) begin
                            count_down[c-3] <= 1'b0;
                        end
                    end
                end
            end else begin : g_nobuf
                assign compare_capture_buffer_a[c] = 16'h0000;
                assign compare_capture_buffer_b[c] = 16'h0000;
            end
        end
    endgenerate

    wire trig_clear = comb_active & ~output_level_control[`OLC_XTD_BIT] & cap_a[1];
    wire glb_wr = bus_req.wr & ~ch_space & bus_req.byte_en[0];

    always_ff @(posedge clk_sys) begin
        if (init) begin
            output_level_control <= `OLC_RESET;
            function_control_reg <= `FUNC_RESET;
            output_master_enable_reg <= `OME_RESET;
            timer_mode_reg <= `MODE_RESET;
        end else begin
            if (glb_wr && bus_req.addr == `REG_OLC) begin
                output_level_control <= bus_req.wdata[7:0] | `OLC_FIXED_ONES;
            end
            if (glb_wr && bus_req.addr == `REG_FUNC) begin
                function_control_reg <= bus_req.wdata[7:0] | `FUNC_RESET;
            end
            if (glb_wr && bus_req.addr == `REG_MODE) begin
                timer_mode_reg <= bus_req.wdata[7:0] & 8'h7f;
            end
            if (trig_clear) begin
                output_master_enable_reg <= `OME_CLEAR_MASK;
            end else if (glb_wr && bus_req.addr == `REG_OME) begin
                output_master_enable_reg <= bus_req.wdata[7:0] | `OME_CLEAR_MASK;
            end
        end
    end

    wire inv_up = comb_active & ~output_level_control[`OLC_UPPER_BIT];
    wire inv_lo = comb_active & ~output_level_control[`OLC_LOWER_BIT];
    wire [5:0] inv_mask = {inv_up, inv_lo, inv_up, inv_up, inv_lo, inv_lo};
    // Enable bit order follows the master enable register layout
    wire [5:0] oe_mask = {output_master_enable_reg[0], output_master_enable_reg[3],
        output_master_enable_reg[1], output_master_enable_reg[2],
        output_master_enable_reg[4], output_master_enable_reg[5]};

    logic [15:0] ch_rd;
    always_comb begin
        ch_rd = 16'h0000;
        for (int i = 0; i < CHANNELS; i++) begin
            if (ch_sel == 4'(i)) begin
                case (ch_off)
                    `CH_CC: ch_rd = {8'h00, counter_control[i] | `CC_FIXED_ONES};
                    `CH_IOF: ch_rd = {8'h00, io_function_control[i]};
                    `CH_CNT: ch_rd = channel_count[i];
                    `CH_GRA: ch_rd = general_compare_capture_a[i];
                    `CH_GRB: ch_rd = general_compare_capture_b[i];
                    `CH_BRA: ch_rd = compare_capture_buffer_a[i];
                    `CH_BRB: ch_rd = compare_capture_buffer_b[i];
                    `CH_FLAGS: ch_rd = {8'h00, 5'h1f, channel_status_reg[i]};
                    default: ch_rd = 16'h0000;
                endcase
            end
        end
    end

    wire [15:0] glb_rd = bus_req.addr == `REG_OLC ? {8'h00, output_level_control}
        : bus_req.addr == `REG_FUNC ? {8'h00, function_control_reg}
        : bus_req.addr == `REG_OME ? {8'h00, output_master_enable_reg}
        : bus_req.addr == `REG_MODE ? {8'h00, timer_mode_reg} : 16'h0000;

    always_ff @(posedge clk_sys) begin
        if (init) begin
            bus_rdata <= 16'h0000;
            pwm_pins <= '0;
            pwm_pins_oe <= '0;
        end else begin
            bus_rdata <= bus_req.rd ? (ch_space ? ch_rd : glb_rd) : 16'h0000;
            pwm_pins <= pwm_raw ^ inv_mask;
            pwm_pins_oe <= oe_mask;
        end
    end
endmodule

/* File: design/timer_cfg.svh */
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define CH_COUNT 5
`define OLC_RESET 8'hff
`define OLC_FIXED_ONES 8'hec
`define OLC_XTD_BIT 4
`define OLC_UPPER_BIT 1
`define OLC_LOWER_BIT 0
`define CC_RESET 8'h80
`define CC_FIXED_ONES 8'h80
`define CNT_RESET 16'h0000
`define GR_RESET 16'hffff
`define BR_RESET 16'hffff
`define IOF_RESET 8'h88
`define MODE_RESET 8'h00
`define FUNC_RESET 8'hc0
`define OME_RESET 8'hff
`define OME_CLEAR_MASK 8'hc0
`define REG_OLC 8'h00
`define REG_FUNC 8'h01
`define REG_OME 8'h02
`define REG_MODE 8'h03
`define REG_CH_BASE 8'h10
`define REG_CH_STRIDE 8'h10
`define CH_CC 4'h0
`define CH_IOF 4'h1
`define CH_CNT 4'h2
`define CH_GRA 4'h4
`define CH_GRB 4'h6
`define CH_BRA 4'h8
`define CH_BRB 4'ha
`define CH_FLAGS 4'hc
`endif

/* File: design/timer_pkg.sv */
package timer_pkg;
    typedef enum logic [1:0] {comb_normal, comb_normal_b, comb_complementary, comb_reset_sync}
        comb_mode_e;
    typedef struct packed {
        logic ch3_pin_a;
        logic ch3_pin_b;
        logic ch4_pin_a;
        logic ch4_pin_b;
        logic ch4_complement_out_a;
        logic ch4_complement_out_b;
    } pwm_pins_s;
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [1:0] byte_en;
        logic [15:0] wdata;
    } bus_req_s;
endpackage

/* File: design/sync_edge.sv */
`timescale 1ns/1ps
module sync_edge #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    initial begin
        if (WIDTH < 1) $error("sync_edge width");
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            level <= '0;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            // A change counts only once the second and third stages agree
            level <= (s2 == s3) ? s2 : level;
        end
    end
    assign rise = (s2 & s3) & ~level;
    assign fall = ~(s2 | s3) & level;
endmodule

/* File: design/prescaler.sv */
`timescale 1ns/1ps
module prescaler (
    input wire logic clk_sys,
    input wire logic rst,
    output logic [3:0] tick
);
    logic [2:0] div;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div <= 3'h0;
        end else begin
            div <= div + 3'h1;
        end
    end
    // One counter serves every channel so equal divisions stay in step
    assign tick[0] = 1'b1;
    assign tick[1] = div[0];
    assign tick[2] = div[1:0] == 2'h3;
    assign tick[3] = div == 3'h7;
endmodule

/* File: testbench/capture_compare_timer_assertions.sv */
`timescale 1ns/1ps
module capture_compare_timer_assertions #(
    parameter int CHANNELS = 5
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic standby,
    input wire timer_pkg::bus_req_s bus_req,
    input wire logic [15:0] bus_rdata,
    input wire logic [3:0] ext_count_clock,
    input wire logic [CHANNELS-1:0] capture_in_a,
    input wire logic [CHANNELS-1:0] capture_in_b,
    input wire logic [CHANNELS-1:0] sync_clear_group,
    input wire timer_pkg::pwm_pins_s pwm_raw,
    input wire timer_pkg::pwm_pins_s pwm_pins,
    input wire timer_pkg::pwm_pins_s pwm_pins_oe
);
    import timer_pkg::*;
    logic [2:0] olc_bits;
    logic [1:0] comb;
    logic [2:0] since_rst;
    wire any_rst = rst | standby;
    wire wr_lo = bus_req.wr & bus_req.byte_en[0];
    wire wr_ome = wr_lo & (bus_req.addr == 8'h02);
    wire rd_olc = bus_req.rd & (bus_req.addr == 8'h00);
    wire [3:0] ch_sel = bus_req.addr[7:4];
    wire [3:0] ch_off = bus_req.addr[3:0];
    wire rd_cc = bus_req.rd & (ch_off == 4'h0) & (ch_sel >= 4'h1) & (ch_sel <= 4'h5);
    wire rd_nobuf = bus_req.rd & (ch_off[3:2] == 2'b10) & (ch_sel >= 4'h1) & (ch_sel <= 4'h3);
    wire combined = comb[1];
    // Shadow of the level and trigger bits; the pins hide the real register
    wire trig_en = combined & ~olc_bits[2];

    always_ff @(posedge clk_sys) begin
        if (any_rst) begin
            olc_bits <= 3'b111;
            comb <= 2'b00;
        end else begin
            if (wr_lo && bus_req.addr == 8'h00) olc_bits <= {bus_req.wdata[4], bus_req.wdata[1:0]};
            if (wr_lo && bus_req.addr == 8'h01) comb <= bus_req.wdata[5:4];
        end
    end

    // Pins and enables are forced low for one edge after release
    always_ff @(posedge clk_sys) begin
        if (any_rst) since_rst <= 3'd0;
        else if (since_rst != 3'd7) since_rst <= since_rst + 3'd1;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (any_rst);

    AST_OLC_FIXED: assert property (rd_olc |=> (bus_rdata[7:0] & 8'hec) == 8'hec)
        else $error("reserved level control bits not read as one");
    AST_CC_BIT7: assert property (rd_cc |=> bus_rdata[7])
        else $error("counter control bit 7 not read as one");
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        any_rst |=> bus_rdata == 16'h0000 && pwm_pins == 6'h00 && pwm_pins_oe == 6'h00)
        else $error("outputs not quiet in reset");
    AST_OE_RESTORE: assert property (since_rst == 3'd1 |-> ##[0:1] pwm_pins_oe == 6'h3f)
        else $error("output enables not restored after reset");
    AST_PIN_PLAIN: assert property (since_rst >= 3'd2 && !$past(combined)
        |-> pwm_pins == $past(pwm_raw)) else $error("pins altered outside combined modes");
    AST_PIN_UPPER: assert property (since_rst >= 3'd2 && $past(combined)
        |-> {pwm_pins.ch3_pin_a, pwm_pins.ch4_pin_a, pwm_pins.ch4_pin_b} ==
        ($past({pwm_raw.ch3_pin_a, pwm_raw.ch4_pin_a, pwm_raw.ch4_pin_b})
        ^ {3{~$past(olc_bits[1])}})) else $error("upper level group wrong");
    AST_PIN_LOWER: assert property (since_rst >= 3'd2 && $past(combined)
        |-> {pwm_pins.ch3_pin_b, pwm_pins.ch4_complement_out_a, pwm_pins.ch4_complement_out_b}
        == ($past({pwm_raw.ch3_pin_b, pwm_raw.ch4_complement_out_a,
        pwm_raw.ch4_complement_out_b}) ^ {3{~$past(olc_bits[0])}}))
        else $error("lower level group wrong");
    AST_OE_HOLD: assert property (since_rst >= 3'd3 && !$past(trig_en, 2)
        && !$past(wr_ome, 2) |-> $stable(pwm_pins_oe)) else $error("enables moved untriggered");
    AST_RDATA_IDLE: assert property (!$past(bus_req.rd) |-> bus_rdata == 16'h0000)
        else $error("read data without a read");
    AST_NO_BUFFER: assert property (rd_nobuf |=> bus_rdata == 16'h0000)
        else $error("buffer seen on channels 0 to 2");
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
    import timer_pkg::*;
    logic clk_sys;
    logic rst;
    logic standby;
    bus_req_s bus_req;
    logic [15:0] bus_rdata;
    logic [3:0] ext_count_clock;
    logic [4:0] capture_in_a;
    logic [4:0] capture_in_b;
    logic [4:0] sync_clear_group;
    pwm_pins_s pwm_raw;
    pwm_pins_s pwm_pins;
    pwm_pins_s pwm_pins_oe;
    int error_cnt;
    int check_count;
    logic [15:0] rv;
    logic [7:0] b;

    capture_compare_timer u_dut (.clk_sys(clk_sys), .rst(rst), .standby(standby),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .ext_count_clock(ext_count_clock),
        .capture_in_a(capture_in_a), .capture_in_b(capture_in_b),
        .sync_clear_group(sync_clear_group), .pwm_raw(pwm_raw), .pwm_pins(pwm_pins),
        .pwm_pins_oe(pwm_pins_oe));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic results;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One idle cycle between accesses keeps each strobe a single clean pulse
    task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
        @(negedge clk_sys);
        bus_req = '{addr: a, wr: 1'b1, rd: 1'b0, byte_en: be, wdata: d};
        @(negedge clk_sys);
        bus_req.wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] be, output logic [15:0] d);
        @(negedge clk_sys);
        bus_req = '{addr: a, wr: 1'b0, rd: 1'b1, byte_en: be, wdata: 16'h0000};
        @(negedge clk_sys);
        bus_req.rd = 1'b0;
        d = bus_rdata;
    endtask

    task automatic rc(input string name, input logic [7:0] a, input logic [1:0] be,
            input logic [15:0] e);
        logic [15:0] d;
        rd(a, be, d);
        chk(name, d & {{8{be[1]}}, {8{be[0]}}}, e);
    endtask

    // Long enough high and low phases to pass the input synchronizer
    task automatic pulse(input int n);
        repeat (n) begin
            @(negedge clk_sys);
            ext_count_clock[0] = 1'b1;
            repeat (4) @(negedge clk_sys);
            ext_count_clock[0] = 1'b0;
            repeat (4) @(negedge clk_sys);
        end
        repeat (6) @(negedge clk_sys);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        results();
    end

    initial begin
        rst = 1'b1;
        standby = 1'b0;
        bus_req = '0;
        ext_count_clock = 4'h0;
        capture_in_a = 5'h00;
        capture_in_b = 5'h00;
        sync_clear_group = 5'h00;
        pwm_raw = 6'h2a;
        error_cnt = 0;
        check_count = 0;
        // Counting rising edges avoids the start-up race of the first falling edge
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        rc("lvl", 8'h00, 2'b01, 16'h00ff);
        for (int k = 0; k < 5; k++) begin
            b = 8'h10 + 8'(k * 16);
            rc("ctrl", b, 2'b01, 16'h0080);
            rc("gen_a", b + 8'h04, 2'b11, 16'hffff);
            rc("gen_b", b + 8'h06, 2'b11, 16'hffff);
            rc("buf_b", b + 8'h0a, 2'b11, k >= 3 ? 16'hffff : 16'h0000);
        end
        wr(8'h10, 2'b01, 16'h0004);
        wr(8'h12, 2'b11, 16'hffff);
        wr(8'h1c, 2'b01, 16'h0000);
        pulse(1);
        rd(8'h1c, 2'b01, rv);
        // Both general registers still hold all ones, so all ones also matched A and B
        chk("wrap", rv[2:0], 3'h7);
        wr(8'h10, 2'b01, 16'h000c);
        pulse(2);
        wr(8'h10, 2'b01, 16'h0014);
        pulse(1);
        rc("count", 8'h12, 2'b11, 16'h0004);
        wr(8'h12, 2'b10, 16'hab00);
        rc("count", 8'h12, 2'b11, 16'hab04);
        wr(8'h10, 2'b01, 16'h0024);
        wr(8'h12, 2'b11, 16'h0000);
        wr(8'h14, 2'b11, 16'h0003);
        wr(8'h1c, 2'b01, 16'h0000);
        pulse(3);
        rc("count", 8'h12, 2'b11, 16'h0000);
        rd(8'h1c, 2'b01, rv);
        chk("match", rv[0], 1'b1);
        wr(8'h40, 2'b01, 16'h0024);
        wr(8'h42, 2'b11, 16'h0000);
        wr(8'h44, 2'b11, 16'h0002);
        wr(8'h48, 2'b11, 16'h1234);
        wr(8'h01, 2'b01, 16'h0001);
        pulse(2);
        rc("gen_a", 8'h44, 2'b11, 16'h1234);
        wr(8'h50, 2'b01, 16'h0004);
        wr(8'h51, 2'b01, 16'h0004);
        wr(8'h52, 2'b11, 16'h0abc);
        wr(8'h54, 2'b11, 16'h1111);
        wr(8'h01, 2'b01, 16'h0005);
        capture_in_a[4] = 1'b1;
        repeat (8) @(negedge clk_sys);
        rc("gen_a", 8'h54, 2'b11, 16'h0abc);
        rc("buf_a", 8'h58, 2'b11, 16'h1111);
        rd(8'h5c, 2'b01, rv);
        chk("capt", rv[0], 1'b1);
        wr(8'h00, 2'b01, 16'h0010);
        repeat (2) @(negedge clk_sys);
        chk("pins", pwm_pins, 16'h002a);
        wr(8'h01, 2'b01, 16'h0025);
        repeat (2) @(negedge clk_sys);
        chk("pins", pwm_pins, 16'h0015);
        wr(8'h00, 2'b01, 16'h0012);
        repeat (2) @(negedge clk_sys);
        chk("pins", pwm_pins, 16'h0039);
        rc("lvl", 8'h00, 2'b01, 16'h00fe);
        chk("oe", pwm_pins_oe, 16'h003f);
        wr(8'h00, 2'b01, 16'h0003);
        wr(8'h21, 2'b01, 16'h0004);
        capture_in_a[1] = 1'b1;
        repeat (8) @(negedge clk_sys);
        rc("enables", 8'h02, 2'b01, 16'h00c0);
        chk("oe", pwm_pins_oe, 16'h0000);
        wr(8'h30, 2'b01, 16'h0002);
        wr(8'h32, 2'b11, 16'h0000);
        // Forty cycles hold exactly ten quarter-rate ticks whatever the prescaler phase
        repeat (39) @(negedge clk_sys);
        rc("div4", 8'h32, 2'b11, 16'h000a);
        wr(8'h30, 2'b01, 16'h0064);
        sync_clear_group[2] = 1'b1;
        @(negedge clk_sys);
        sync_clear_group[2] = 1'b0;
        rc("sync", 8'h32, 2'b11, 16'h0000);
        standby = 1'b1;
        repeat (2) @(negedge clk_sys);
        standby = 1'b0;
        rc("lvl", 8'h00, 2'b01, 16'h00ff);
        rc("gen_a", 8'h54, 2'b11, 16'hffff);
        rc("buf_a", 8'h58, 2'b11, 16'hffff);
        rc("ctrl", 8'h50, 2'b01, 16'h0080);
        results();
    end
endmodule

bind capture_compare_timer capture_compare_timer_assertions #(.CHANNELS(CHANNELS)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .standby(standby), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .ext_count_clock(ext_count_clock), .capture_in_a(capture_in_a),
    .capture_in_b(capture_in_b), .sync_clear_group(sync_clear_group), .pwm_raw(pwm_raw),
    .pwm_pins(pwm_pins), .pwm_pins_oe(pwm_pins_oe));
